// >>> rtl/time_trigger_waveform_output.sv
// Waveform stage of one time-triggered output unit with pin routing.
// Assumes targetReached and otherUnitPins come from logic on mclk.
//
// How it works
// - Waveform starts only when the unit is enabled and target time reached.
// - Code 000 drives high idle to low at trigger and holds low.
// - Code 001 drives low idle to high at trigger and holds high.
// - Code 010 emits one low pulse of programmed width, then high.
// - Code 011 emits one high pulse of programmed width, then low.
// - Code 100 repeats low pulses each cycle width; zero count is endless.
// - Code 101 repeats high pulses each cycle width; zero count is endless.
// - Code 110 shifts the 16-bit pattern out LSB first, looping, counted.
// - Pin select 0 to 6 picks the output pin; 7 to 15 drive none.
// - Units selecting the same pin are ORed onto it.
// - Pulse width counts in 8 ns steps.
// - Cycle or bit width counts in 1 ns steps.
`timescale 1ns/1ps
`include "time_trigger_map.svh"
module time_trigger_waveform_output
  import time_trigger_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdata,
  input wire logic targetReached,
  input wire logic [6:0] otherUnitPins,
  output logic [6:0] gpioOut
);

  // ***************************************************************
  // Reset release.
  // ***************************************************************
  logic rstPipe;
  logic rstN;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rstPipe <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstPipe <= 1'b1;
      rstN <= rstPipe;
    end
  end

  // ***************************************************************
  // Register block.
  // ***************************************************************
  cfg_if cfg ();

  time_trigger_regs u_regs (
    .mclk(mclk),
    .rstN(rstN),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWrite(regWrite),
    .regRead(regRead),
    .regRdata(regRdata),
    .cfg(cfg.regs)
  );

  // ***************************************************************
  // Helper functions.
  // ***************************************************************
  function automatic logic idleLevel(input pattern_t p);
    case (p)
      falling_step_pattern: return 1'b1;
      low_single_pulse_pattern: return 1'b1;
      low_periodic_pattern: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : idleLevel

  function automatic logic [31:0] widthCycles(input logic [33:0] ns);
    logic [33:0] q;
    q = (ns + 34'(`CLK_PERIOD_NS - 1)) / 34'(`CLK_PERIOD_NS);
    if (q == 34'h0) begin
      q = 34'h1;
    end
    if (q[33:32] != 2'b00) begin
      q = 34'h0FFFFFFFF;
    end
    return q[31:0];
  endfunction : widthCycles

  // ***************************************************************
  // Decoded configuration.
  // ***************************************************************
  pattern_t pat;
  logic en;
  logic idle;
  logic [31:0] pulseCyc;
  logic [31:0] periodCyc;
  logic isEdge;
  logic isPulse;
  logic isPeriodic;
  logic isSerial;

  assign pat = cfg.pattern;
  assign en = cfg.enable;
  assign idle = idleLevel(pat);
  assign pulseCyc = widthCycles(34'(cfg.pulseWidth) * 34'(`PULSE_STEP_NS));
  assign periodCyc = widthCycles(34'(cfg.cycleWidth) * 34'(`WIDTH_STEP_NS));
  assign isEdge = (pat == falling_step_pattern) ||
                  (pat == rising_step_pattern);
  assign isPulse = (pat == low_single_pulse_pattern) ||
                   (pat == high_single_pulse_pattern);
  assign isPeriodic = (pat == low_periodic_pattern) ||
                      (pat == high_periodic_pattern);
  assign isSerial = (pat == serial_bitpattern_mode);

  // ***************************************************************
  // Engine state.
  // ***************************************************************
  wave_state_t state;
  logic [31:0] phase;
  logic [15:0] iter;
  logic [3:0] bitIdx;
  logic unitLevel;
  logic start;
  logic periodEnd;
  logic lastRep;
  logic finish;
  logic [31:0] nextPhase;
  logic [3:0] nextBit;
  logic startLevel;
  logic next_level;

  assign start = (state == ST_WAIT) && en && targetReached;
  assign periodEnd = (phase == periodCyc - 32'h1);
  assign lastRep = (cfg.repeatCount != 16'h0000) &&
                   (iter + 16'h0001 == cfg.repeatCount);
  assign nextPhase = periodEnd ? 32'h0 : phase + 32'h1;
  assign nextBit = bitIdx + 4'h1;

  always_comb begin
    finish = 1'b1;
    if (isPulse) begin
      finish = (phase == pulseCyc - 32'h1);
    end else if (isPeriodic || isSerial) begin
      finish = periodEnd && lastRep;
    end
  end

  always_comb begin
    startLevel = ~idle;
    if (isSerial) begin
      startLevel = cfg.bitPattern[0];
    end else if (pat == unused_pattern) begin
      startLevel = idle;
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      state <= ST_WAIT;
    end else begin
      case (state)
        ST_WAIT: begin
          if (start) begin
            state <= (isEdge || pat == unused_pattern) ? ST_HOLD : ST_RUN;
          end
        end
        ST_RUN: begin
          if (!en) begin
            state <= ST_WAIT;
          end else if (finish) begin
            state <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (!en) begin
            state <= ST_WAIT;
          end
        end
        default: state <= ST_WAIT;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      phase <= 32'h0;
    end else if (state == ST_RUN && en) begin
      phase <= isPulse ? phase + 32'h1 : nextPhase;
    end else begin
      phase <= 32'h0;
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      iter <= 16'h0000;
      bitIdx <= 4'h0;
    end else if (state != ST_RUN) begin
      iter <= 16'h0000;
      bitIdx <= 4'h0;
    end else if (periodEnd) begin
      iter <= iter + 16'h0001;
      bitIdx <= nextBit;
    end
  end

  always_comb begin
    next_level = idle;
    case (state)
      ST_WAIT: next_level = start ? startLevel : idle;
      ST_RUN: begin
        if (!en || finish) begin
          next_level = idle;
        end else if (isPeriodic) begin
          next_level = (nextPhase < pulseCyc) ? ~idle : idle;
        end else if (isSerial) begin
          next_level = periodEnd ? cfg.bitPattern[nextBit] : unitLevel;
        end else begin
          next_level = unitLevel;
        end
      end
      ST_HOLD: next_level = en ? unitLevel : idle;
      default: next_level = idle;
    endcase
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      unitLevel <= 1'b0;
    end else begin
      unitLevel <= next_level;
    end
  end

  assign cfg.running = (state == ST_RUN);
  assign cfg.finished = (state == ST_HOLD);
  assign cfg.level = unitLevel;

  // ***************************************************************
  // Pin routing.
  // ***************************************************************
  logic [6:0] pinMask;

  always_comb begin
    pinMask = 7'h00;
    if (cfg.pinSel <= `LAST_PIN && unitLevel) begin
      pinMask = 7'(7'h01 << cfg.pinSel[2:0]);
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      gpioOut <= 7'h00;
    end else begin
      gpioOut <= otherUnitPins | pinMask;
    end
  end

  // ***************************************************************
  // Assertions.
  // ***************************************************************
  property p_start;
    @(posedge mclk) disable iff (!rstN)
    (state == ST_WAIT && !(en && targetReached)) |=> state == ST_WAIT;
  endproperty
  a_start: assert property (p_start)
    else $error("Unit left waiting without enable and target time.");

  property p_fall;
    @(posedge mclk) disable iff (!rstN)
    (start && pat == falling_step_pattern) |=>
      (!unitLevel && state == ST_HOLD);
  endproperty
  a_fall: assert property (p_fall)
    else $error("Falling step did not drive low.");

  property p_rise;
    @(posedge mclk) disable iff (!rstN)
    (start && pat == rising_step_pattern) |=>
      (unitLevel && state == ST_HOLD);
  endproperty
  a_rise: assert property (p_rise)
    else $error("Rising step did not drive high.");

  property p_low_pulse;
    @(posedge mclk) disable iff (!rstN)
    (state == ST_RUN && en && pat == low_single_pulse_pattern &&
     phase == pulseCyc - 32'h1) |=> (unitLevel && state == ST_HOLD);
  endproperty
  a_low_pulse: assert property (p_low_pulse)
    else $error("Low pulse did not return high at its end.");

  property p_high_pulse;
    @(posedge mclk) disable iff (!rstN)
    (start && pat == high_single_pulse_pattern &&
     cfg.pulseWidth == 16'h0001) |=> unitLevel ##1 !unitLevel;
  endproperty
  a_high_pulse: assert property (p_high_pulse)
    else $error("High pulse shape is wrong.");

  property p_endless;
    @(posedge mclk) disable iff (!rstN)
    (state == ST_RUN && en && isPeriodic &&
     cfg.repeatCount == 16'h0000) |=> state != ST_HOLD;
  endproperty
  a_endless: assert property (p_endless)
    else $error("Endless periodic output stopped.");

  property p_counted;
    @(posedge mclk) disable iff (!rstN)
    (state == ST_RUN && en && pat == high_periodic_pattern &&
     periodEnd && lastRep) |=> (state == ST_HOLD && !unitLevel);
  endproperty
  a_counted: assert property (p_counted)
    else $error("Counted periodic output did not stop low.");

  property p_serial;
    @(posedge mclk) disable iff (!rstN)
    (state == ST_RUN && en && isSerial && periodEnd && !lastRep) |=>
      unitLevel == $past(cfg.bitPattern[nextBit]);
  endproperty
  a_serial: assert property (p_serial)
    else $error("Serial pattern bit is wrong.");

  property p_pin;
    @(posedge mclk) disable iff (!rstN)
    (unitLevel && cfg.pinSel > `LAST_PIN) |=>
      gpioOut == $past(otherUnitPins);
  endproperty
  a_pin: assert property (p_pin)
    else $error("Unused pin select drove a pin.");

  property p_or;
    @(posedge mclk) disable iff (!rstN)
    (unitLevel && cfg.pinSel == 4'h3) |=> gpioOut[3];
  endproperty
  a_or: assert property (p_or)
    else $error("Selected pin not driven by the unit.");

  property p_width;
    @(posedge mclk) disable iff (!rstN)
    (start && pat == low_single_pulse_pattern &&
     cfg.pulseWidth == 16'h000A) |=> !unitLevel [*8] ##1 unitLevel;
  endproperty
  a_width: assert property (p_width)
    else $error("An 80 ns pulse did not last eight cycles.");

  property p_cycle;
    @(posedge mclk) disable iff (!rstN)
    (start && pat == high_periodic_pattern && cfg.pulseWidth == 16'h0003
     && cfg.cycleWidth == 32'h00000033 && cfg.repeatCount != 16'h0001)
      |=> unitLevel [*3] ##1 !unitLevel [*3] ##1 unitLevel;
  endproperty
  a_cycle: assert property (p_cycle)
    else $error("A 51 ns cycle did not last six cycles.");

  property p_unused;
    @(posedge mclk) disable iff (!rstN)
    (start && pat == unused_pattern) |=> (!unitLevel && state == ST_HOLD);
  endproperty
  a_unused: assert property (p_unused)
    else $error("Undefined pattern moved the output.");

endmodule : time_trigger_waveform_output

// >>> pkg/time_trigger_map.svh
// Offsets, field positions, reset values and timing figures of one
// time-triggered waveform unit. Assumes 16-bit registers on a plain port.
`ifndef TIME_TRIGGER_MAP_SVH
`define TIME_TRIGGER_MAP_SVH

// ***************************************************************
// Register offsets.
// ***************************************************************
`define OFS_CONFIG_A 16'h0228
`define OFS_CONFIG_B 16'h022A
`define OFS_CYCLE_LOW 16'h022C
`define OFS_CYCLE_HIGH 16'h022E
`define OFS_REPEAT_COUNT 16'h0230
`define OFS_BIT_PATTERN 16'h0232
`define OFS_UNIT_CONTROL 16'h0240
`define OFS_UNIT_STATUS 16'h0242

// ***************************************************************
// Field positions and masks.
// ***************************************************************
`define POS_PIN_SEL 0
`define POS_PATTERN 4
`define POS_ENABLE 0
`define POS_ST_RUNNING 0
`define POS_ST_FINISHED 1
`define POS_ST_LEVEL 2
`define MASK_CONFIG_A 16'hFF7F
`define PIN_COUNT 7
`define LAST_PIN 4'h6

// ***************************************************************
// Reset values.
// ***************************************************************
`define RST_CONFIG_A 16'h3C00
`define RST_CLEAR 16'h0000

// ***************************************************************
// Timing figures in nanoseconds.
// ***************************************************************
`define CLK_PERIOD_NS 10
`define PULSE_STEP_NS 8
`define WIDTH_STEP_NS 1

`endif

// >>> pkg/time_trigger_pkg.sv
// Types shared by the waveform unit and its register block.
// Assumes nothing beyond a SystemVerilog compiler.
package time_trigger_pkg;

  // ***************************************************************
  // Pattern codes and engine states.
  // ***************************************************************
  typedef enum logic [2:0] {
    falling_step_pattern = 3'h0,
    rising_step_pattern = 3'h1,
    low_single_pulse_pattern = 3'h2,
    high_single_pulse_pattern = 3'h3,
    low_periodic_pattern = 3'h4,
    high_periodic_pattern = 3'h5,
    serial_bitpattern_mode = 3'h6,
    unused_pattern = 3'h7
  } pattern_t;

  typedef enum logic [1:0] {
    ST_WAIT,
    ST_RUN,
    ST_HOLD
  } wave_state_t;

endpackage : time_trigger_pkg

// >>> pkg/cfg_if.sv
// Carries configuration from the register block to the engine and
// engine status back. Assumes one clock domain.
`timescale 1ns/1ps
interface cfg_if;
  import time_trigger_pkg::*;
  pattern_t pattern;
  logic [3:0] pinSel;
  logic [15:0] pulseWidth;
  logic [31:0] cycleWidth;
  logic [15:0] repeatCount;
  logic [15:0] bitPattern;
  logic enable;
  logic running;
  logic finished;
  logic level;

  modport regs (
    output pattern, pinSel, pulseWidth, cycleWidth, repeatCount,
    output bitPattern, enable,
    input running, finished, level
  );

  modport engine (
    input pattern, pinSel, pulseWidth, cycleWidth, repeatCount,
    input bitPattern, enable,
    output running, finished, level
  );
endinterface : cfg_if

// >>> rtl/time_trigger_regs.sv
// Register block of the waveform unit on a plain 16-bit port.
// Assumes a synchronised active-low reset and same-clock strobes.
`timescale 1ns/1ps
`include "time_trigger_map.svh"
module time_trigger_regs
  import time_trigger_pkg::*;
(
  input wire logic mclk,
  input wire logic rstN,
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdata,
  cfg_if.regs cfg
);

  logic [15:0] configA;
  logic [15:0] configB;
  logic [15:0] cycleLow;
  logic [15:0] cycleHigh;
  logic [15:0] repeatCount;
  logic [15:0] bitPattern;
  logic enable;
  logic [15:0] next_rdata;

  // ***************************************************************
  // Writes.
  // ***************************************************************
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      configA <= `RST_CONFIG_A;
      configB <= `RST_CLEAR;
      cycleLow <= `RST_CLEAR;
      cycleHigh <= `RST_CLEAR;
      repeatCount <= `RST_CLEAR;
      bitPattern <= `RST_CLEAR;
      enable <= 1'b0;
    end else if (regWrite) begin
      case (regAddr)
        `OFS_CONFIG_A: configA <= regWdata & `MASK_CONFIG_A;
        `OFS_CONFIG_B: configB <= regWdata;
        `OFS_CYCLE_LOW: cycleLow <= regWdata;
        `OFS_CYCLE_HIGH: cycleHigh <= regWdata;
        `OFS_REPEAT_COUNT: repeatCount <= regWdata;
        `OFS_BIT_PATTERN: bitPattern <= regWdata;
        `OFS_UNIT_CONTROL: enable <= regWdata[`POS_ENABLE];
        default: enable <= enable;
      endcase
    end
  end

  // ***************************************************************
  // Reads, answered in the following cycle; unmapped reads give zero.
  // ***************************************************************
  always_comb begin
    next_rdata = 16'h0000;
    case (regAddr)
      `OFS_CONFIG_A: next_rdata = configA;
      `OFS_CONFIG_B: next_rdata = configB;
      `OFS_CYCLE_LOW: next_rdata = cycleLow;
      `OFS_CYCLE_HIGH: next_rdata = cycleHigh;
      `OFS_REPEAT_COUNT: next_rdata = repeatCount;
      `OFS_BIT_PATTERN: next_rdata = bitPattern;
      `OFS_UNIT_CONTROL: next_rdata[`POS_ENABLE] = enable;
      `OFS_UNIT_STATUS: begin
        next_rdata[`POS_ST_RUNNING] = cfg.running;
        next_rdata[`POS_ST_FINISHED] = cfg.finished;
        next_rdata[`POS_ST_LEVEL] = cfg.level;
      end
      default: next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      regRdata <= 16'h0000;
    end else if (regRead) begin
      regRdata <= next_rdata;
    end else begin
      regRdata <= 16'h0000;
    end
  end

  assign cfg.pattern = pattern_t'(configA[`POS_PATTERN +: 3]);
  assign cfg.pinSel = configA[`POS_PIN_SEL +: 4];
  assign cfg.pulseWidth = configB;
  assign cfg.cycleWidth = {cycleHigh, cycleLow};
  assign cfg.repeatCount = repeatCount;
  assign cfg.bitPattern = bitPattern;
  assign cfg.enable = enable;

endmodule : time_trigger_regs

// >>> test/gpio_observer.sv
// Model of the logic that watches the general-purpose output pins.
// Assumes pins are sampled on mclk and one pin is watched at a time.
`timescale 1ns/1ps
module gpio_observer (
  input wire logic mclk,
  input wire logic [6:0] gpioOut,
  input wire logic [2:0] pinIdx,
  input wire logic activeHigh,
  input wire logic clear,
  output logic [31:0] activeCycles,
  output logic [31:0] edges
);
  // ***************************************************************
  // Active-level and active-going edge counters.
  // ***************************************************************
  logic prev;
  logic now;

  assign now = gpioOut[pinIdx] ~^ activeHigh;

  always_ff @(posedge mclk) begin
    if (clear) begin
      activeCycles <= 32'h0;
      edges <= 32'h0;
      prev <= now;
    end else begin
      activeCycles <= activeCycles + {31'h0, now};
      edges <= edges + {31'h0, now & ~prev};
      prev <= now;
    end
  end
endmodule : gpio_observer

// >>> test/time_trigger_waveform_output_bench.sv
// Self-checking bench for the time-triggered waveform unit.
// Assumes the register map header and package of the design.
`timescale 1ns/1ps
`include "time_trigger_map.svh"
module time_trigger_waveform_output_bench;
  import time_trigger_pkg::*;
  // ***************************************************************
  // Signals, design and observer.
  // ***************************************************************
  logic mclk;
  logic resetn;
  logic [15:0] regAddr;
  logic [15:0] regWdata;
  logic regWrite;
  logic regRead;
  logic [15:0] regRdata;
  logic targetReached;
  logic [6:0] otherUnitPins;
  logic [6:0] gpioOut;
  logic activeHigh;
  logic obsClear;
  logic [31:0] activeCycles;
  logic [31:0] edges;
  int miscompares;
  int check_count;

  time_trigger_waveform_output i_dut (.mclk(mclk), .resetn(resetn),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata),
    .targetReached(targetReached), .otherUnitPins(otherUnitPins),
    .gpioOut(gpioOut));

  gpio_observer i_obs (.mclk(mclk), .gpioOut(gpioOut), .pinIdx(3'h2),
    .activeHigh(activeHigh), .clear(obsClear),
    .activeCycles(activeCycles), .edges(edges));

  // ***************************************************************
  // Access, compare and closing tasks.
  // ***************************************************************
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic reg_write(input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [15:0] a, output logic [15:0] d);
    @(posedge mclk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRead <= 1'b0;
    #1;
    d = regRdata;
  endtask : reg_read

  // Programs one run on pin 2, triggers it and waits for the finish; endless runs wait 200 cycles and check running.
  task automatic run_wave(input logic [2:0] code, input logic [15:0] pw,
    input logic [31:0] cyc, input logic [15:0] cnt,
    input logic [15:0] pat, input logic hi, input bit endless);
    logic [15:0] st;
    int n;
    reg_write(`OFS_UNIT_CONTROL, 16'h0000);
    reg_write(`OFS_CONFIG_A, {9'h0, code, 4'h2});
    reg_write(`OFS_CONFIG_B, pw);
    reg_write(`OFS_CYCLE_LOW, cyc[15:0]);
    reg_write(`OFS_CYCLE_HIGH, cyc[31:16]);
    reg_write(`OFS_REPEAT_COUNT, cnt);
    reg_write(`OFS_BIT_PATTERN, pat);
    reg_write(`OFS_UNIT_CONTROL, 16'h0001);
    activeHigh <= hi;
    repeat (3) @(posedge mclk);
    obsClear <= 1'b1;
    @(posedge mclk);
    obsClear <= 1'b0;
    targetReached <= 1'b1;
    if (endless) begin
      repeat (200) @(posedge mclk);
      reg_read(`OFS_UNIT_STATUS, st);
      check("endless running", st[1:0], 2'b01);
    end else begin
      n = 0;
      st = 16'h0;
      while (st[`POS_ST_FINISHED] !== 1'b1) begin
        n++;
        if (n > 1000) begin
          miscompares++;
          stop_test();
        end
        reg_read(`OFS_UNIT_STATUS, st);
      end
    end
    repeat (3) @(posedge mclk);
    targetReached <= 1'b0;
  endtask : run_wave

  // ***************************************************************
  // Clock, watchdog and main sequence.
  // ***************************************************************
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    repeat (50000) @(posedge mclk);
    miscompares++;
    stop_test();
  end

  initial begin
    logic [15:0] d;
    logic [15:0] offs [5];
    int e;
    int act;
    logic b;
    logic p;
    offs = '{`OFS_CONFIG_B, `OFS_CYCLE_LOW, `OFS_CYCLE_HIGH,
      `OFS_REPEAT_COUNT, `OFS_BIT_PATTERN};
    miscompares = 0;
    check_count = 0;
    resetn = 1'b0;
    regAddr = 16'h0;
    regWdata = 16'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
    targetReached = 1'b0;
    otherUnitPins = 7'h0;
    activeHigh = 1'b1;
    obsClear = 1'b0;
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    // Reset values, masks, unmapped place and read-data timing.
    check("pins idle", gpioOut, 7'h01);
    reg_read(`OFS_CONFIG_A, d);
    check("config a reset", d, `RST_CONFIG_A);
    @(posedge mclk);
    #1;
    check("read data after answer", regRdata, 16'h0);
    reg_read(`OFS_UNIT_STATUS, d);
    check("status reset", d, 16'h0004);
    reg_write(`OFS_CONFIG_A, 16'hFFFF);
    reg_read(`OFS_CONFIG_A, d);
    check("config a mask", d, `MASK_CONFIG_A);
    reg_write(`OFS_CONFIG_A, `RST_CONFIG_A);
    reg_read(16'h0234, d);
    check("unmapped read", d, 16'h0);
    for (int i = 0; i < 5; i++) begin
      reg_write(offs[i], 16'hA5C3 ^ 16'(i));
      reg_read(offs[i], d);
      check("register readback", d, 16'hA5C3 ^ 16'(i));
    end
    // Falling step: nothing before the target, low after it.
    reg_write(`OFS_UNIT_CONTROL, 16'h0001);
    repeat (4) @(posedge mclk);
    check("step waits target", gpioOut, 7'h01);
    targetReached <= 1'b1;
    repeat (14) @(posedge mclk);
    check("falling step", gpioOut, 7'h00);
    targetReached <= 1'b0;
    // Rising step on pin selects 0 to 7 and 15, other units ORed in.
    otherUnitPins <= 7'h28;
    for (int s = 0; s < 9; s++) begin
      reg_write(`OFS_UNIT_CONTROL, 16'h0000);
      reg_write(`OFS_CONFIG_A, 16'h0010 | 16'(s == 8 ? 15 : s));
      targetReached <= 1'b1;
      repeat (4) @(posedge mclk);
      check("disabled unit", gpioOut, 7'h28);
      reg_write(`OFS_UNIT_CONTROL, 16'h0001);
      repeat (4) @(posedge mclk);
      check("rising step pin", gpioOut,
        7'h28 | (s < 7 ? 7'h01 << s : 7'h00));
      targetReached <= 1'b0;
    end
    otherUnitPins <= 7'h00;
    // Single pulses: 10 x 8 ns is 8 cycles, 8 ns rounds up to 1.
    run_wave(3'h2, 16'd10, 32'd0, 16'd0, 16'h0, 1'b0, 1'b0);
    check("low pulse cycles", activeCycles, 32'd8);
    check("low pulse count", edges, 32'd1);
    run_wave(3'h3, 16'd1, 32'd0, 16'd0, 16'h0, 1'b1, 1'b0);
    check("high pulse cycles", activeCycles, 32'd1);
    check("high pulse count", edges, 32'd1);
    // Periodic: 24 ns active is 3 cycles, 50 and 51 ns are 5 and 6.
    run_wave(3'h4, 16'd3, 32'd50, 16'd4, 16'h0, 1'b0, 1'b0);
    check("low periodic cycles", activeCycles, 32'd12);
    check("low periodic count", edges, 32'd4);
    run_wave(3'h5, 16'd3, 32'd51, 16'd3, 16'h0, 1'b1, 1'b0);
    check("high periodic cycles", activeCycles, 32'd9);
    check("high periodic count", edges, 32'd3);
    run_wave(3'h5, 16'd3, 32'd51, 16'd0, 16'h0, 1'b1, 1'b1);
    check("endless edges", edges > 32'd20, 32'd1);
    // Serial pattern, 20 ns bits, 20 bits so the index wraps.
    run_wave(3'h6, 16'd0, 32'd20, 16'd20, 16'hA0C5, 1'b1, 1'b0);
    e = 0;
    act = 0;
    p = 1'b0;
    for (int i = 0; i < 20; i++) begin
      b = 16'hA0C5 >> (i % 16);
      act += b ? 2 : 0;
      e += (b && !p) ? 1 : 0;
      p = b;
    end
    check("serial cycles", activeCycles, 32'(act));
    check("serial edges", edges, 32'(e));
    // Unused code stays at the idle level.
    run_wave(3'h7, 16'd1, 32'd10, 16'd1, 16'hFFFF, 1'b1, 1'b0);
    check("unused code", activeCycles, 32'd0);
    reg_write(`OFS_UNIT_CONTROL, 16'h0000);
    stop_test();
  end
endmodule : time_trigger_waveform_output_bench
